// ==== pkg/stpc_defs.svh ====
// stpc_defs.svh: offsets, fields, reset values and counts of the shared test pin block
// assumes a 32-bit apb register bus with word-aligned registers
`ifndef STPC_DEFS_SVH
`define STPC_DEFS_SVH
`define STPC_OFS_CTRL 8'h00
`define STPC_OFS_PROBE 8'h04
`define STPC_OFS_CHK 8'h08
`define STPC_OFS_STATUS 8'h0C
`define STPC_OFS_SCAN 8'h10
`define STPC_CTRL_DEDICATED 0
`define STPC_CTRL_TRST_RSV 1
`define STPC_CTRL_PROBE_KILL 2
`define STPC_CTRL_CHK_GO 3
`define STPC_PROBE_EN_FIRST 8
`define STPC_PROBE_EN_SECOND 9
`define STPC_CTRL_RST 2'b00
`define STPC_PROBE_RST 10'h000
`define STPC_CHK_RST 32'h0000_0000
`define STPC_TMS_RESET_TCKS 5
`define STPC_CHK_BITS 6'h20
`endif

// ==== pkg/stpc_pkg.sv ====
// stpc_pkg: types of the shared test pin block
// assumes stpc_defs.svh holds the numbers
package stpc_pkg;
	typedef enum logic [3:0] {
		TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PAU_DR,
		TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PAU_IR,
		TAP_EX2_IR, TAP_UPD_IR
	} stpc_tap_t;
endpackage

// ==== rtl/stpc_top.sv ====
// stpc_top: shared boundary-scan and probe pin control with apb registers
// assumes all pin inputs are asynchronous and tck runs far slower than i_core_clk
`timescale 1ns/1ps
`include "stpc_defs.svh"
module stpc_top (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_tms_pin,
	input wire logic i_tck_pin,
	input wire logic i_tdi_pin,
	input wire logic i_trst_pin,
	input wire logic i_tck_user_out,
	input wire logic i_tck_user_oe,
	input wire logic i_tdi_user_out,
	input wire logic i_tdi_user_oe,
	input wire logic i_tdo_user_out,
	input wire logic i_tdo_user_oe,
	input wire logic i_trst_user_out,
	input wire logic i_trst_user_oe,
	input wire logic i_probe_user_out_first,
	input wire logic i_probe_user_oe_first,
	input wire logic i_probe_user_out_second,
	input wire logic i_probe_user_oe_second,
	input wire logic [15:0] i_probe_nodes,
	output logic o_tck_out,
	output logic o_tck_oe,
	output logic o_tdi_out,
	output logic o_tdi_oe,
	output logic o_tdo_out,
	output logic o_tdo_oe,
	output logic o_trst_out,
	output logic o_trst_oe,
	output logic o_probe_out_first,
	output logic o_probe_oe_first,
	output logic o_probe_out_second,
	output logic o_probe_oe_second,
	output stpc_pkg::stpc_tap_t o_tap_state
);
	import stpc_pkg::*;

	function automatic stpc_tap_t tap_next(input stpc_tap_t s, input logic tms);
		case (s)
			TAP_RESET: tap_next = tms ? TAP_RESET : TAP_IDLE;
			TAP_IDLE: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR: tap_next = tms ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
			TAP_SH_DR: tap_next = tms ? TAP_EX1_DR : TAP_SH_DR;
			TAP_EX1_DR: tap_next = tms ? TAP_UPD_DR : TAP_PAU_DR;
			TAP_PAU_DR: tap_next = tms ? TAP_EX2_DR : TAP_PAU_DR;
			TAP_EX2_DR: tap_next = tms ? TAP_UPD_DR : TAP_SH_DR;
			TAP_UPD_DR: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR: tap_next = tms ? TAP_RESET : TAP_CAP_IR;
			TAP_CAP_IR: tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
			TAP_SH_IR: tap_next = tms ? TAP_EX1_IR : TAP_SH_IR;
			TAP_EX1_IR: tap_next = tms ? TAP_UPD_IR : TAP_PAU_IR;
			TAP_PAU_IR: tap_next = tms ? TAP_EX2_IR : TAP_PAU_IR;
			TAP_EX2_IR: tap_next = tms ? TAP_UPD_IR : TAP_SH_IR;
			TAP_UPD_IR: tap_next = tms ? TAP_SEL_DR : TAP_IDLE;
			default: tap_next = TAP_RESET;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// reset release and pin synchronisers

	logic rst_s1_q, rst_n_q;
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_s1_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q <= rst_s1_q;
		end
	end

	logic [3:0] pin_s1_q, pin_s2_q;
	logic tck_d1_q;
	always_ff @(posedge i_core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pin_s1_q <= 4'b1001; // trst and tms idle high
			pin_s2_q <= 4'b1001;
			tck_d1_q <= 1'b0;
		end else begin
			pin_s1_q <= {i_trst_pin, i_tdi_pin, i_tck_pin, i_tms_pin};
			pin_s2_q <= pin_s1_q;
			tck_d1_q <= pin_s2_q[1];
		end
	end
	logic tms_s, tck_rise, tck_fall, tdi_s, trst_act;
	assign tms_s = pin_s2_q[0];
	assign tck_rise = pin_s2_q[1] & ~tck_d1_q;
	assign tck_fall = ~pin_s2_q[1] & tck_d1_q;
	assign tdi_s = pin_s2_q[2];

	////////////////////////////////////////////////////////////////////////////////
	// apb registers

	logic [1:0] ctrl_q;
	logic probe_lock_q, chk_go_q;
	logic [9:0] probe_q;
	logic [31:0] chk_q, scan_q;
	logic chk_busy_q, test_active_q;
	logic [31:0] rdata;
	logic hit, wr_en;
	stpc_tap_t tap_q;
	assign trst_act = ctrl_q[`STPC_CTRL_TRST_RSV] & ~pin_s2_q[3];
	assign wr_en = i_psel & i_penable & i_pwrite & o_pready;

	always_comb begin
		hit = 1'b1;
		rdata = 32'h0000_0000;
		case (i_paddr)
			`STPC_OFS_CTRL: rdata = {29'h0, probe_lock_q, ctrl_q};
			`STPC_OFS_PROBE: rdata = {22'h0, probe_q};
			`STPC_OFS_CHK: rdata = chk_q;
			`STPC_OFS_STATUS: rdata = {24'h0, trst_act, probe_lock_q, chk_busy_q,
				test_active_q, 4'(tap_q)};
			`STPC_OFS_SCAN: rdata = scan_q;
			default: hit = 1'b0;
		endcase
	end

	always_ff @(posedge i_core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			o_pready <= 1'b0;
			o_prdata <= 32'h0000_0000;
			o_pslverr <= 1'b0;
		end else begin
			o_pready <= i_psel & i_penable & ~o_pready;
			o_prdata <= (i_psel & i_penable & ~i_pwrite) ? rdata : 32'h0000_0000;
			o_pslverr <= i_psel & i_penable & ~o_pready & ~hit;
		end
	end

	always_ff @(posedge i_core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ctrl_q <= `STPC_CTRL_RST;
			probe_q <= `STPC_PROBE_RST;
			chk_q <= `STPC_CHK_RST;
			chk_go_q <= 1'b0;
		end else begin
			chk_go_q <= wr_en & (i_paddr == `STPC_OFS_CTRL) & i_pwdata[`STPC_CTRL_CHK_GO];
			if (wr_en && i_paddr == `STPC_OFS_CTRL)
				ctrl_q <= i_pwdata[1:0];
			if (wr_en && i_paddr == `STPC_OFS_PROBE)
				probe_q <= i_pwdata[9:0];
			if (wr_en && i_paddr == `STPC_OFS_CHK)
				chk_q <= i_pwdata;
		end
	end

	always_ff @(posedge i_core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			probe_lock_q <= 1'b0;
		end else if (wr_en && i_paddr == `STPC_OFS_CTRL && i_pwdata[`STPC_CTRL_PROBE_KILL]) begin
			probe_lock_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// tap controller and shared pin ownership

	always_ff @(posedge i_core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			tap_q <= TAP_RESET;
		end else if (trst_act) begin
			tap_q <= TAP_RESET;
		end else if (tck_rise) begin
			tap_q <= tap_next(tap_q, tms_s);
		end
	end

	always_ff @(posedge i_core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			test_active_q <= 1'b0;
		end else if (ctrl_q[`STPC_CTRL_DEDICATED]) begin
			test_active_q <= 1'b1;
		end else if (!tms_s) begin
			test_active_q <= 1'b1;
		end else if (tap_q == TAP_RESET || trst_act) begin
			test_active_q <= 1'b0;
		end
	end

	logic [31:0] dr_q;
	logic [3:0] ir_q;
	logic scan_out_q;
	always_ff @(posedge i_core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			dr_q <= 32'h0000_0000;
			ir_q <= 4'h0;
			scan_q <= 32'h0000_0000;
			scan_out_q <= 1'b0;
		end else begin
			if (tck_rise) begin
				case (tap_q)
					TAP_CAP_DR: dr_q <= {16'h0000, i_probe_nodes};
					TAP_SH_DR: dr_q <= {tdi_s, dr_q[31:1]};
					TAP_UPD_DR: scan_q <= dr_q;
					TAP_CAP_IR: ir_q <= 4'h1;
					TAP_SH_IR: ir_q <= {tdi_s, ir_q[3:1]};
					default: ;
				endcase
			end
			if (tck_fall)
				scan_out_q <= (tap_q == TAP_SH_IR) ? ir_q[0] : dr_q[0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checksum shift-out on tdo

	logic [5:0] chk_cnt_q;
	logic [31:0] chk_sh_q;
	always_ff @(posedge i_core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			chk_busy_q <= 1'b0;
			chk_cnt_q <= 6'h00;
			chk_sh_q <= 32'h0000_0000;
		end else if (chk_go_q && !chk_busy_q) begin
			chk_busy_q <= 1'b1;
			chk_cnt_q <= `STPC_CHK_BITS;
			chk_sh_q <= chk_q;
		end else if (chk_busy_q && tck_fall) begin
			chk_sh_q <= {1'b0, chk_sh_q[31:1]};
			chk_cnt_q <= chk_cnt_q - 6'h01;
			if (chk_cnt_q == 6'h01)
				chk_busy_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pad drivers

	logic shifting;
	assign shifting = (tap_q == TAP_SH_DR) || (tap_q == TAP_SH_IR);
	always_ff @(posedge i_core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			o_tck_out <= 1'b0;
			o_tck_oe <= 1'b0;
			o_tdi_out <= 1'b0;
			o_tdi_oe <= 1'b0;
			o_tdo_out <= 1'b0;
			o_tdo_oe <= 1'b0;
			o_trst_out <= 1'b0;
			o_trst_oe <= 1'b0;
			o_tap_state <= TAP_RESET;
		end else begin
			o_tap_state <= tap_q;
			o_tck_out <= i_tck_user_out;
			o_tck_oe <= ~test_active_q & i_tck_user_oe;
			o_tdi_out <= i_tdi_user_out;
			o_tdi_oe <= ~test_active_q & i_tdi_user_oe;
			o_trst_out <= i_trst_user_out;
			o_trst_oe <= ~ctrl_q[`STPC_CTRL_TRST_RSV] & i_trst_user_oe;
			if (test_active_q) begin
				o_tdo_out <= scan_out_q;
				o_tdo_oe <= shifting;
			end else if (chk_busy_q) begin
				o_tdo_out <= chk_sh_q[0];
				o_tdo_oe <= 1'b1;
			end else begin
				o_tdo_out <= i_tdo_user_out;
				o_tdo_oe <= i_tdo_user_oe;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			o_probe_out_first <= 1'b0;
			o_probe_oe_first <= 1'b0;
			o_probe_out_second <= 1'b0;
			o_probe_oe_second <= 1'b0;
		end else begin
			if (probe_q[`STPC_PROBE_EN_FIRST] && !probe_lock_q) begin
				o_probe_out_first <= i_probe_nodes[probe_q[3:0]];
				o_probe_oe_first <= 1'b1;
			end else begin
				o_probe_out_first <= i_probe_user_out_first;
				o_probe_oe_first <= i_probe_user_oe_first;
			end
			if (probe_q[`STPC_PROBE_EN_SECOND] && !probe_lock_q) begin
				o_probe_out_second <= i_probe_nodes[probe_q[7:4]];
				o_probe_oe_second <= 1'b1;
			end else begin
				o_probe_out_second <= i_probe_user_out_second;
				o_probe_oe_second <= i_probe_user_oe_second;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	logic [2:0] tms_hi_cnt_q;
	always_ff @(posedge i_core_clk or negedge rst_n_q) begin
		if (!rst_n_q)
			tms_hi_cnt_q <= 3'd0;
		else if (tck_rise)
			tms_hi_cnt_q <= !tms_s ? 3'd0 : (tms_hi_cnt_q == 3'd7) ? 3'd7 : tms_hi_cnt_q + 3'd1;
	end

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!rst_n_q);

	sequence s_trst_low;
		trst_act;
	endsequence
	sequence s_tap_in_reset;
		tap_q == TAP_RESET;
	endsequence

	a_tms_five_reset: assert property (tms_hi_cnt_q >= 3'(`STPC_TMS_RESET_TCKS) |-> s_tap_in_reset)
		else $error("tap not in reset after five tms-high tck cycles");
	a_trst_tap_reset: assert property (s_trst_low |=> s_tap_in_reset)
		else $error("test reset did not reset tap");
	a_trst_release: assert property (s_trst_low ##1 (tms_s && !ctrl_q[0]) |=> !test_active_q)
		else $error("test reset did not release shared pins");
	a_flex_entry: assert property (!ctrl_q[0] && !tms_s |=> test_active_q ##1 !o_tck_oe)
		else $error("tms low did not claim shared pins");
	a_hold_test: assert property (test_active_q && tap_q != TAP_RESET && !trst_act
		|=> test_active_q)
		else $error("shared pins left test use early");
	a_release_io: assert property ($fell(test_active_q) |=> o_tdi_oe == $past(i_tdi_user_oe))
		else $error("tdi not returned to user io");
	a_dedicated_hold: assert property (ctrl_q[0] |=> test_active_q)
		else $error("dedicated mode lost test use");
	a_trst_user_io: assert property (!ctrl_q[1] |=> o_trst_oe == $past(i_trst_user_oe))
		else $error("unreserved test reset not user io");
	a_chk_drive: assert property (chk_busy_q && !test_active_q |=> o_tdo_oe)
		else $error("checksum not driving tdo");
	a_probe_follow: assert property (probe_q[8] && !probe_lock_q
		|=> o_probe_out_first == $past(i_probe_nodes[probe_q[3:0]]) && o_probe_oe_first)
		else $error("probe does not follow node");
	a_probe_kill: assert property (probe_lock_q |=> probe_lock_q && !($rose(o_probe_oe_first)
		&& !$past(i_probe_user_oe_first)))
		else $error("probe re-enabled after disable");
endmodule

// ==== bench/stpc_jtag_host.sv ====
// stpc_jtag_host: behavioural scan controller on the shared test pins
// assumes i_clk is the core clock; one tck period spans eight of its cycles
`timescale 1ns/1ps
module stpc_jtag_host (
	input wire logic i_clk,
	input wire logic i_tdo,
	output logic o_tck,
	output logic o_tms,
	output logic o_tdi
);
	initial begin
		o_tck = 1'b0;
		o_tms = 1'b1;
		o_tdi = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// n tck cycles, tms/tdi lsb first, tdo taken late in the high phase
	task automatic run(input int n, input logic [31:0] tms_v, input logic [31:0] tdi_v,
		output logic [31:0] tdo_v);
		tdo_v = '0;
		for (int i = 0; i < n; i++) begin
			o_tms <= tms_v[i];
			o_tdi <= tdi_v[i];
			repeat (4) @(posedge i_clk);
			o_tck <= 1'b1;
			repeat (3) @(posedge i_clk);
			tdo_v[i] = i_tdo;
			@(posedge i_clk);
			// falling edge; tck parks low after the last cycle
			o_tck <= 1'b0;
		end
	endtask
endmodule

// ==== bench/tb_top.sv ====
// tb_top: register and pin checks of the shared test pin block
// assumes one apb wait state and the scan host model on the test pins
`timescale 1ns/1ps
`include "stpc_defs.svh"
module tb_top;
	import stpc_pkg::*;
	logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, trst_low = 0;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd, tv;
	logic [15:0] nodes = 16'h1008;
	logic [11:0] usr = 12'hBFF;
	logic pready, pslverr, er, tck, tms, tdi, tck_oe, tdo_o, tdo_oe, trst_o, trst_oe;
	logic pa_o, pa_oe, pb_o, tdi_oe;
	stpc_tap_t tap;
	int errors = 0, tests_run = 0;
	always #12.5 clk = ~clk;
	stpc_jtag_host host (.i_clk(clk), .i_tdo(tdo_o), .o_tck(tck), .o_tms(tms), .o_tdi(tdi));
	stpc_top DUT (.i_core_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_tms_pin(tms), .i_tck_pin(tck),
		.i_tdi_pin(tdi), .i_trst_pin(trst_oe ? trst_o : !trst_low),
		.i_tck_user_out(usr[0]), .i_tck_user_oe(usr[1]), .i_tdi_user_out(usr[2]),
		.i_tdi_user_oe(usr[3]), .i_tdo_user_out(usr[4]), .i_tdo_user_oe(usr[5]),
		.i_trst_user_out(usr[6]), .i_trst_user_oe(usr[7]), .i_probe_user_out_first(usr[8]),
		.i_probe_user_oe_first(usr[9]), .i_probe_user_out_second(usr[10]),
		.i_probe_user_oe_second(usr[11]), .i_probe_nodes(nodes), .o_tck_out(),
		.o_tck_oe(tck_oe), .o_tdi_out(), .o_tdi_oe(tdi_oe), .o_tdo_out(tdo_o), .o_tdo_oe(tdo_oe),
		.o_trst_out(trst_o), .o_trst_oe(trst_oe), .o_probe_out_first(pa_o),
		.o_probe_oe_first(pa_oe), .o_probe_out_second(pb_o), .o_probe_oe_second(),
		.o_tap_state(tap));
	////////////////////////////////////////////////////////////////////////////////
	task wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20)
			errors++;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, e);
	endtask
	task wrap_up;
		if (errors == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		wt(20000);
		errors++;
		wrap_up;
	end
	initial begin
		wt(5);
		rst_n <= 1'b1;
		wt(3);
		rdc(`STPC_OFS_CTRL, 32'h0000_0000);
		rdc(`STPC_OFS_PROBE, 32'h0000_0000);
		rdc(`STPC_OFS_STATUS, 32'h0000_0000);
		apb(1'b1, 8'h14, 32'hFFFF_FFFF);
		chk(er, 1'b1);
		// flexible entry, capture and shift, then five tms-high cycles
		host.run(1, 32'h0, 32'h0, tv);
		wt(4);
		rdc(`STPC_OFS_STATUS, 32'h0000_0011);
		chk(tck_oe, 1'b0);
		chk(tdi_oe, 1'b0);
		host.run(3, 32'h1, 32'h0, tv);
		host.run(32, 32'h8000_0000, 32'h9C3A_5E17, tv);
		chk(tv, {16'h0000, 16'h1008});
		host.run(3, 32'h7, 32'h0, tv);
		wt(2);
		chk(tap, TAP_SEL_IR);
		chk(tck_oe, 1'b0);
		host.run(1, 32'h1, 32'h0, tv);
		wt(4);
		chk(tck_oe, 1'b1);
		chk(tdi_oe, 1'b1);
		rdc(`STPC_OFS_STATUS, 32'h0000_0000);
		rdc(`STPC_OFS_SCAN, 32'h9C3A_5E17);
		// checksum drives tdo, then gives it back
		usr[5] <= 1'b0;
		apb(1'b1, `STPC_OFS_CHK, 32'h6B3C_95A1);
		apb(1'b1, `STPC_OFS_CTRL, 32'h0000_0008);
		wt(2);
		chk(tdo_oe, 1'b1);
		rdc(`STPC_OFS_STATUS, 32'h0000_0020);
		host.run(32, 32'hFFFF_FFFF, 32'h0, tv);
		chk(tv, 32'h6B3C_95A1);
		wt(6);
		chk(tdo_oe, 1'b0);
		// probes follow nodes, then are locked out for good
		nodes <= 16'h1000;
		apb(1'b1, `STPC_OFS_PROBE, 32'h0000_03C3);
		wt(2);
		chk({pa_oe, pa_o, pb_o}, 3'b101);
		nodes <= 16'h0008;
		wt(3);
		chk({pa_o, pb_o}, 2'b10);
		nodes <= 16'h1000;
		apb(1'b1, `STPC_OFS_CTRL, 32'h0000_0004);
		wt(2);
		chk({pa_o, pb_o}, 2'b10);
		nodes <= 16'h0000;
		apb(1'b1, `STPC_OFS_CTRL, 32'h0000_0000);
		rdc(`STPC_OFS_CTRL, 32'h0000_0004);
		chk(pa_o, 1'b1);
		// test reset only once reserved
		host.run(2, 32'h2, 32'h0, tv);
		wt(4);
		rdc(`STPC_OFS_STATUS, 32'h0000_0052);
		chk(trst_oe, 1'b1);
		apb(1'b1, `STPC_OFS_CTRL, 32'h0000_0006);
		wt(2);
		chk(trst_oe, 1'b0);
		trst_low <= 1'b1;
		wt(6);
		rdc(`STPC_OFS_STATUS, 32'h0000_00C0);
		chk(tck_oe, 1'b1);
		trst_low <= 1'b0;
		wt(4);
		rdc(`STPC_OFS_STATUS, 32'h0000_0040);
		// dedicated mode never releases the pins
		apb(1'b1, `STPC_OFS_CTRL, 32'h0000_0005);
		host.run(5, 32'h1F, 32'h0, tv);
		wt(4);
		chk(tck_oe, 1'b0);
		rdc(`STPC_OFS_STATUS, 32'h0000_0050);
		wrap_up;
	end
endmodule
